//--- rtl/shrp_defs.vh
// constants of the sensor host register port: offsets, fields, reset values, codes
// assumes inclusion by bare name from the design files under rtl/
`ifndef SHRP_DEFS_VH
`define SHRP_DEFS_VH

// ************************************************************
// register offsets (i2c register address space)
// ************************************************************
`define SHRP_ADDR_PART_ID     8'hd1
`define SHRP_ADDR_SOFT_RESET  8'he0
`define SHRP_ADDR_SMOOTH      8'hf1
`define SHRP_ADDR_HS_CODE     8'hf2
`define SHRP_ADDR_TOP         8'hff
`define SHRP_SPI_ADDR_MSB     1'b1

// ************************************************************
// fields, reset values and command codes
// ************************************************************
`define SHRP_SMOOTH_RST       3'h0
`define SHRP_HS_CODE_RST      3'h1
`define SHRP_HS_CODE_BASE     5'h01
`define SHRP_SOFT_RESET_KEY   8'he6
`define SHRP_PAST_END_DATA    8'h00
`define SHRP_TGT_ADDR_LOW     7'h70
`define SHRP_TGT_ADDR_HIGH    7'h56
`define SHRP_LAST_BIT         3'h7

`endif

//--- rtl/shrp_sync.v
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none

module shrp_sync (
  input  wire clk,
  input  wire rst,
  input  wire pin,
  output reg  level_ff,
  output wire rise,
  output wire fall
);
  reg s1_ff;
  reg s2_ff;
  reg s3_ff;
  reg prev_ff;

  // only s2 and s3 are compared; s1 may be metastable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff    <= 1'b1;
      s2_ff    <= 1'b1;
      s3_ff    <= 1'b1;
      level_ff <= 1'b1;
      prev_ff  <= 1'b1;
    end else begin
      s1_ff   <= pin;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      prev_ff <= level_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign rise = level_ff & ~prev_ff;
  assign fall = ~level_ff & prev_ff;
endmodule // shrp_sync

`default_nettype wire

//--- rtl/shrp_port.v
// host register port: i2c target and spi target in front of the sensor registers
// assumes one 10 mhz sys_clk, pins asynchronous, core registers readable combinationally
//
// Summary of operation
// - three-bit code field selects recognised high-speed master code 08h to 0Fh.
// - smoothing depth: 000 off, then 2,4,8,16, and 32 for 101 upward.
// - any write to smoothing depth register re-initialises the filter.
// - after reset the smoothing filter is off, field zero.
// - writing E6h to reset command triggers soft reset; other values do nothing.
// - read-only part identifier register returns a fixed code.
// - i2c target address 70h with select pin low, 56h with it high.
// - i2c write: address byte, then register address and data pairs, then stop.
// - i2c read: set address by write, restart, address with read bit, data returned.
// - i2c read auto-increments while host acknowledges; nack ends the burst.
// - reads past address FFh return 00h.
// - spi write: control 0, seven-bit address, data byte; pairs may repeat.
// - chip select high ends the spi transaction and drops partial framing.
// - spi read: control 1 and address, data out on sdo or shared line.
// - spi read increments address after each byte until chip select rises.
// - i2c target supports standard and fast rates; high-speed frames are not sampled at a 10 mhz sys_clk.
// - three-wire select 0 gives four-wire spi, 1 gives three-wire.
`timescale 1ns/1ps
`default_nettype none
`include "shrp_defs.vh"

module shrp_port #(
  parameter [7:0] PART_ID = 8'ha5 // arbitrary value
) (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire       scl_sck,
  input  wire       sda_sdi_i,
  output wire       sda_sdi_o,
  output wire       sda_sdi_oe,
  input  wire       sdo_i,
  output wire       sdo_o,
  output wire       sdo_oe,
  input  wire       csb_n,
  input  wire       three_wire_select,
  output wire [7:0] core_rd_addr,
  input  wire [7:0] core_rd_data,
  output reg        core_wr_stb_ff,
  output reg  [7:0] core_wr_addr_ff,
  output reg  [7:0] core_wr_data_ff,
  output reg  [5:0] filter_depth_ff,
  output reg        filter_reinit_ff,
  output reg        soft_reset_ff,
  output wire [7:0] hs_code,
  output reg        hs_mode_ff
);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire scl_lvl;
  wire scl_rise;
  wire scl_fall;
  wire sda_lvl;
  wire sda_rise;
  wire sda_fall;
  wire csb_lvl;
  wire sel_lvl;

  shrp_sync u_scl (.clk(sys_clk), .rst(rst), .pin(scl_sck),
                   .level_ff(scl_lvl), .rise(scl_rise), .fall(scl_fall));
  shrp_sync u_sda (.clk(sys_clk), .rst(rst), .pin(sda_sdi_i),
                   .level_ff(sda_lvl), .rise(sda_rise), .fall(sda_fall));
  shrp_sync u_csb (.clk(sys_clk), .rst(rst), .pin(csb_n),
                   .level_ff(csb_lvl), .rise(), .fall());
  shrp_sync u_sel (.clk(sys_clk), .rst(rst), .pin(sdo_i),
                   .level_ff(sel_lvl), .rise(), .fall());

  // ************************************************************
  // register state and read mux
  // ************************************************************
  reg  [2:0] smooth_ff;
  reg  [2:0] code_ff;
  reg  [7:0] i2c_ptr_ff;
  reg  [7:0] spi_ptr_ff;
  reg        i2c_past_ff;
  reg        spi_past_ff;
  wire       spi_act = ~csb_lvl;

  assign hs_code      = {`SHRP_HS_CODE_BASE, code_ff};
  assign core_rd_addr = spi_act ? spi_ptr_ff : i2c_ptr_ff;

  // locally held registers answer here; the rest comes from the core
  function [7:0] rd_byte;
    input [7:0] a;
    input       past;
    begin
      if (past) begin
        rd_byte = `SHRP_PAST_END_DATA;
      end else if (a == `SHRP_ADDR_PART_ID) begin
        rd_byte = PART_ID;
      end else if (a == `SHRP_ADDR_SMOOTH) begin
        rd_byte = {5'h00, smooth_ff};
      end else if (a == `SHRP_ADDR_HS_CODE) begin
        rd_byte = {5'h00, code_ff};
      end else if (a == `SHRP_ADDR_SOFT_RESET) begin
        rd_byte = 8'h00;
      end else begin
        rd_byte = core_rd_data;
      end
    end
  endfunction

  wire [7:0] i2c_rd = rd_byte(i2c_ptr_ff, i2c_past_ff);
  wire [7:0] spi_rd = rd_byte(spi_ptr_ff, spi_past_ff);

  // ************************************************************
  // i2c target
  // ************************************************************
  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_DEV  = 3'h1;
  localparam [2:0] I_ACK  = 3'h2;
  localparam [2:0] I_RECV = 3'h3;
  localparam [2:0] I_SEND = 3'h4;
  localparam [2:0] I_MACK = 3'h5;

  reg  [2:0] i_st_ff;
  reg  [3:0] i_cnt_ff;
  reg  [7:0] i_sr_ff;
  reg        i_rw_ff;
  reg        i_data_ff;   // next received byte is data, not register address
  reg        i_oe_ff;
  reg        i_macked_ff;
  reg        i_wr_ff;
  reg  [7:0] i_wa_ff;
  reg  [7:0] i_wd_ff;
  wire [6:0] tgt_addr  = sel_lvl ? `SHRP_TGT_ADDR_HIGH : `SHRP_TGT_ADDR_LOW;
  wire       i_start   = sda_fall & scl_lvl & ~spi_act;
  wire       i_stop    = sda_rise & scl_lvl;
  // limitation: high-speed frames need sys_clk well above 10 mhz to be sampled
  wire [7:0] i_byte    = {i_sr_ff[6:0], sda_lvl};

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      i_st_ff     <= I_IDLE;
      i_cnt_ff    <= 4'h0;
      i_sr_ff     <= 8'h00;
      i_rw_ff     <= 1'b0;
      i_data_ff   <= 1'b0;
      i_oe_ff     <= 1'b0;
      i_macked_ff <= 1'b0;
      i_wr_ff     <= 1'b0;
      i_wa_ff     <= 8'h00;
      i_wd_ff     <= 8'h00;
      i2c_ptr_ff  <= 8'h00;
      i2c_past_ff <= 1'b0;
      hs_mode_ff  <= 1'b0;
    end else begin
      i_wr_ff <= 1'b0;
      if (spi_act || i_stop) begin
        i_st_ff    <= I_IDLE;
        i_oe_ff    <= 1'b0;
        hs_mode_ff <= hs_mode_ff & ~i_stop;
      end else if (i_start) begin
        i_st_ff  <= I_DEV;
        i_cnt_ff <= 4'h0;
        i_oe_ff  <= 1'b0;
      end else begin
        case (i_st_ff)
          I_DEV: begin
            if (scl_rise) begin
              i_sr_ff  <= i_byte;
              i_cnt_ff <= i_cnt_ff + 4'h1;
            end else if (scl_fall && i_cnt_ff == 4'h8) begin
              if (i_sr_ff[7:1] == tgt_addr) begin
                i_rw_ff   <= i_sr_ff[0];
                i_data_ff <= 1'b0;
                i_oe_ff   <= 1'b1;
                i_st_ff   <= I_ACK;
              end else begin
                // master code is left unacknowledged; high speed runs to stop
                if (i_sr_ff == hs_code) begin
                  hs_mode_ff <= 1'b1;
                end
                i_st_ff <= I_IDLE;
              end
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              i_cnt_ff <= 4'h0;
              if (i_rw_ff) begin
                i_oe_ff <= ~i2c_rd[7];
                i_sr_ff <= {i2c_rd[6:0], 1'b0};
                i_st_ff <= I_SEND;
              end else begin
                i_oe_ff <= 1'b0;
                i_st_ff <= I_RECV;
              end
            end
          end
          I_RECV: begin
            if (scl_rise) begin
              i_sr_ff  <= i_byte;
              i_cnt_ff <= i_cnt_ff + 4'h1;
            end else if (scl_fall && i_cnt_ff == 4'h8) begin
              i_oe_ff   <= 1'b1;
              i_st_ff   <= I_ACK;
              i_data_ff <= ~i_data_ff;
              if (i_data_ff) begin
                i_wr_ff <= 1'b1;
                i_wa_ff <= i2c_ptr_ff;
                i_wd_ff <= i_sr_ff;
              end else begin
                i2c_ptr_ff  <= i_sr_ff;
                i2c_past_ff <= 1'b0;
              end
            end
          end
          I_SEND: begin
            if (scl_rise) begin
              i_cnt_ff <= i_cnt_ff + 4'h1;
            end else if (scl_fall) begin
              if (i_cnt_ff == 4'h8) begin
                i_oe_ff <= 1'b0;
                i_st_ff <= I_MACK;
              end else begin
                i_oe_ff <= ~i_sr_ff[7];
                i_sr_ff <= {i_sr_ff[6:0], 1'b0};
              end
            end
          end
          I_MACK: begin
            if (scl_rise) begin
              i_macked_ff <= ~sda_lvl;
              if (!sda_lvl) begin
                i2c_ptr_ff <= i2c_ptr_ff + 8'h01;
                if (i2c_ptr_ff == `SHRP_ADDR_TOP) begin
                  i2c_past_ff <= 1'b1;
                end
              end
            end else if (scl_fall) begin
              if (i_macked_ff) begin
                i_cnt_ff <= 4'h0;
                i_oe_ff  <= ~i2c_rd[7];
                i_sr_ff  <= {i2c_rd[6:0], 1'b0};
                i_st_ff  <= I_SEND;
              end else begin
                i_st_ff <= I_IDLE;
              end
            end
          end
          default: begin
            i_st_ff <= I_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // spi target, mode 0/3: sample on rise, shift out on fall
  // ************************************************************
  reg  [2:0] s_cnt_ff;
  reg  [2:0] s_tx_cnt_ff;
  reg  [7:0] s_sr_ff;
  reg  [7:0] s_tx_ff;
  reg        s_hdr_ff;
  reg        s_rd_ff;
  reg        s_out_ff;
  reg        s_wr_ff;
  reg  [7:0] s_wa_ff;
  reg  [7:0] s_wd_ff;
  wire [7:0] s_byte = {s_sr_ff[6:0], sda_lvl};

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_cnt_ff    <= 3'h0;
      s_tx_cnt_ff <= 3'h0;
      s_sr_ff     <= 8'h00;
      s_tx_ff     <= 8'h00;
      s_hdr_ff    <= 1'b1;
      s_rd_ff     <= 1'b0;
      s_out_ff    <= 1'b0;
      s_wr_ff     <= 1'b0;
      s_wa_ff     <= 8'h00;
      s_wd_ff     <= 8'h00;
      spi_ptr_ff  <= 8'h00;
      spi_past_ff <= 1'b0;
    end else begin
      s_wr_ff <= 1'b0;
      if (!spi_act) begin
        s_cnt_ff    <= 3'h0;
        s_tx_cnt_ff <= 3'h0;
        s_hdr_ff    <= 1'b1;
        s_rd_ff     <= 1'b0;
      end else if (scl_rise && !s_rd_ff) begin
        s_sr_ff  <= s_byte;
        s_cnt_ff <= s_cnt_ff + 3'h1;
        if (s_cnt_ff == `SHRP_LAST_BIT) begin
          s_hdr_ff <= ~s_hdr_ff;
          if (s_hdr_ff) begin
            spi_ptr_ff  <= {`SHRP_SPI_ADDR_MSB, s_byte[6:0]};
            spi_past_ff <= 1'b0;
            s_rd_ff     <= s_sr_ff[6];
          end else begin
            s_wr_ff <= 1'b1;
            s_wa_ff <= spi_ptr_ff;
            s_wd_ff <= s_byte;
          end
        end
      end else if (scl_fall && s_rd_ff) begin
        s_tx_cnt_ff <= s_tx_cnt_ff + 3'h1;
        if (s_tx_cnt_ff == 3'h0) begin
          s_out_ff <= spi_rd[7];
          s_tx_ff  <= {spi_rd[6:0], 1'b0};
        end else begin
          s_out_ff <= s_tx_ff[7];
          s_tx_ff  <= {s_tx_ff[6:0], 1'b0};
        end
        if (s_tx_cnt_ff == `SHRP_LAST_BIT) begin
          spi_ptr_ff <= spi_ptr_ff + 8'h01;
          if (spi_ptr_ff == `SHRP_ADDR_TOP) begin
            spi_past_ff <= 1'b1;
          end
        end
      end
    end
  end

  // shared line is open-drain for i2c and push-pull for a three-wire read
  wire s_drive    = spi_act & s_rd_ff;
  assign sda_sdi_o  = spi_act & s_out_ff;
  assign sda_sdi_oe = i_oe_ff | (s_drive & three_wire_select);
  assign sdo_o      = s_out_ff;
  assign sdo_oe     = s_drive & ~three_wire_select;

  // ************************************************************
  // register writes
  // ************************************************************
  wire       wr_go   = i_wr_ff | s_wr_ff;
  wire [7:0] wr_addr = s_wr_ff ? s_wa_ff : i_wa_ff;
  wire [7:0] wr_data = s_wr_ff ? s_wd_ff : i_wd_ff;
  reg  [5:0] nxt_depth;

  always @* begin
    case (smooth_ff)
      3'h0:    nxt_depth = 6'h00;
      3'h1:    nxt_depth = 6'h02;
      3'h2:    nxt_depth = 6'h04;
      3'h3:    nxt_depth = 6'h08;
      3'h4:    nxt_depth = 6'h10;
      default: nxt_depth = 6'h20;
    endcase
  end

  // upper bits are dropped; the host is expected to write them as zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      smooth_ff        <= `SHRP_SMOOTH_RST;
      code_ff          <= `SHRP_HS_CODE_RST;
      filter_depth_ff  <= 6'h00;
      filter_reinit_ff <= 1'b0;
      soft_reset_ff    <= 1'b0;
      core_wr_stb_ff   <= 1'b0;
      core_wr_addr_ff  <= 8'h00;
      core_wr_data_ff  <= 8'h00;
    end else begin
      filter_reinit_ff <= 1'b0;
      soft_reset_ff    <= 1'b0;
      core_wr_stb_ff   <= 1'b0;
      filter_depth_ff  <= nxt_depth;
      if (soft_reset_ff) begin
        smooth_ff <= `SHRP_SMOOTH_RST;
        code_ff   <= `SHRP_HS_CODE_RST;
      end else if (wr_go) begin
        if (wr_addr == `SHRP_ADDR_SMOOTH) begin
          smooth_ff        <= wr_data[2:0];
          filter_reinit_ff <= 1'b1;
        end else if (wr_addr == `SHRP_ADDR_HS_CODE) begin
          code_ff <= wr_data[2:0];
        end else if (wr_addr == `SHRP_ADDR_SOFT_RESET) begin
          soft_reset_ff <= (wr_data == `SHRP_SOFT_RESET_KEY);
        end else if (wr_addr != `SHRP_ADDR_PART_ID) begin
          core_wr_stb_ff  <= 1'b1;
          core_wr_addr_ff <= wr_addr;
          core_wr_data_ff <= wr_data;
        end
      end
    end
  end
endmodule // shrp_port

`default_nettype wire

//--- tb/shrp_checker.sv
// checker for the host register port: config outputs, pulses, pin enables
// assumes it is bound onto shrp_port, single sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module shrp_checker (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       csb_n,
  input wire logic       three_wire_select,
  input wire logic       sda_sdi_oe,
  input wire logic       sdo_oe,
  input wire logic       core_wr_stb_ff,
  input wire logic [7:0] core_wr_addr_ff,
  input wire logic [5:0] filter_depth_ff,
  input wire logic       filter_reinit_ff,
  input wire logic       soft_reset_ff,
  input wire logic [7:0] hs_code
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************
  // sequences
  // ****************
  sequence s_cfg_rst;
    hs_code == 8'h09 && filter_depth_ff == 6'h00;
  endsequence
  // csb sync takes about four cycles, so six idle samples give margin
  sequence s_idle6;
    csb_n [*6];
  endsequence
  // ****************
  // properties
  // ****************
  property p_reset_vals;
    $fell(rst) |-> s_cfg_rst ##0 (!sda_sdi_oe && !sdo_oe);
  endproperty
  property p_hs_base;
    hs_code[7:3] == 5'h01;
  endproperty
  property p_depth;
    filter_depth_ff inside {6'h00, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20};
  endproperty
  property p_reinit;
    filter_reinit_ff |=> !filter_reinit_ff;
  endproperty
  property p_soft;
    soft_reset_ff |-> ##[1:3] s_cfg_rst;
  endproperty
  property p_fwd;
    core_wr_stb_ff |-> !(core_wr_addr_ff inside {8'hd1, 8'he0, 8'hf1, 8'hf2});
  endproperty
  property p_cs_end;
    s_idle6 |-> !sdo_oe;
  endproperty
  property p_wire;
    sda_sdi_oe && !csb_n |-> three_wire_select;
  endproperty
  property p_excl;
    !(sdo_oe && sda_sdi_oe);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("reset values wrong");
  a_hs_base: assert property (p_hs_base) else $error("hs code base wrong");
  a_depth: assert property (p_depth) else $error("depth not decodable");
  a_reinit: assert property (p_reinit) else $error("reinit pulse too long");
  a_soft: assert property (p_soft) else $error("soft reset not restoring");
  a_fwd: assert property (p_fwd) else $error("local register forwarded");
  a_cs_end: assert property (p_cs_end) else $error("sdo driven with csb high");
  a_wire: assert property (p_wire) else $error("sdi driven in four-wire");
  a_excl: assert property (p_excl) else $error("both data pins driven");
endmodule // shrp_checker
bind shrp_port shrp_checker u_shrp_checker (.sys_clk(sys_clk), .rst(rst), .csb_n(csb_n),
  .three_wire_select(three_wire_select), .sda_sdi_oe(sda_sdi_oe), .sdo_oe(sdo_oe),
  .core_wr_stb_ff(core_wr_stb_ff), .core_wr_addr_ff(core_wr_addr_ff),
  .filter_depth_ff(filter_depth_ff), .filter_reinit_ff(filter_reinit_ff),
  .soft_reset_ff(soft_reset_ff), .hs_code(hs_code));
`default_nettype wire

//--- tb/shrp_host.sv
// host model: i2c or spi mode 3 master on the shared pins
// assumes pins paced by sys_clk; bench resolves the open-drain line
`timescale 1ns/1ps
`default_nettype none
module shrp_host #(
  parameter int H = 8
) (
  input  wire logic sys_clk,
  input  wire logic sda_line,
  input  wire logic sdo_line,
  input  wire logic three_wire_select,
  output var  logic sck,
  output var  logic sda_drv,
  output var  logic csb_n
);
  // half period 800 ns (eight cycles): pin sync needs about four of them
  initial begin
    sck = 1'b1;
    sda_drv = 1'b1;
    csb_n = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // data set mid-low, read at end of high; fits i2c and spi alike
  task automatic bit1(input logic v, output logic r);
    sck <= 1'b0;
    w(H / 2);
    sda_drv <= v;
    w(H / 2);
    sck <= 1'b1;
    w(H);
    r = (csb_n || three_wire_select) ? sda_line : sdo_line;
  endtask
  task automatic xfer(input logic [7:0] v, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) bit1(v[i], r[i]);
  endtask
  task automatic i2c_start();
    sda_drv <= 1'b0;
    w(H);
  endtask
  task automatic i2c_restart();
    sck <= 1'b0;
    w(H / 2);
    sda_drv <= 1'b1;
    w(H / 2);
    sck <= 1'b1;
    w(H);
    i2c_start();
  endtask
  task automatic i2c_stop();
    sck <= 1'b0;
    w(H / 2);
    sda_drv <= 1'b0;
    w(H / 2);
    sck <= 1'b1;
    w(H);
    sda_drv <= 1'b1;
    w(H);
  endtask
  task automatic i2c_byte(input logic [7:0] v, input logic ai, output logic [7:0] r,
                          output logic ack);
    xfer(v, r);
    bit1(ai, ack);
  endtask
  task automatic spi_begin();
    csb_n <= 1'b0;
    w(H);
  endtask
  task automatic spi_end();
    sda_drv <= 1'b1;
    w(H);
    csb_n <= 1'b1;
    w(2 * H);
  endtask
endmodule // shrp_host
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the host register port, i2c and spi sides
// assumes the host model drives the pins and a small core memory answers reads
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] PID = 8'h3c; // arbitrary value
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic       tws = 1'b0;
  logic       addr_sel = 1'b0;
  logic       nak, b;
  logic [7:0] r0;
  logic [7:0] mem [256];
  logic [7:0] q [$];
  logic [2:0] sm, hc;
  wire        sck, sda_drv, csb_n, sda_o, sda_oe, sdo_o, sdo_oe;
  wire        sda_line, sdo_line, wr_stb, reinit, sreset, hs_mode;
  wire  [7:0] rd_addr, wr_addr, wr_data, hs_code;
  wire  [5:0] depth;
  int         errors = 0, checks_done = 0, n_re = 0, n_sr = 0, k;
  // {field, decoded depth}
  logic [8:0] rows [8] = '{9'h000, 9'h042, 9'h084, 9'h0c8, 9'h110, 9'h160, 9'h1a0, 9'h1e0};
  // open-drain sda with pull-up; undriven sdo carries addr_sel while csb_n is high, else pulled up
  assign sda_line = (sda_oe ? sda_o : 1'b1) & sda_drv;
  assign sdo_line = sdo_oe ? sdo_o : (csb_n ? addr_sel : 1'b1);
  always #50 sys_clk = ~sys_clk;
  initial foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  always @(posedge sys_clk) begin
    if (wr_stb) mem[wr_addr] <= wr_data;
    if (reinit) n_re <= n_re + 1;
    if (sreset) n_sr <= n_sr + 1;
  end
  shrp_port #(.PART_ID(PID)) u_shrp_port (.sys_clk(sys_clk), .rst(rst), .scl_sck(sck),
    .sda_sdi_i(sda_line), .sda_sdi_o(sda_o), .sda_sdi_oe(sda_oe), .sdo_i(sdo_line),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .csb_n(csb_n), .three_wire_select(tws),
    .core_rd_addr(rd_addr), .core_rd_data(mem[rd_addr]), .core_wr_stb_ff(wr_stb),
    .core_wr_addr_ff(wr_addr), .core_wr_data_ff(wr_data), .filter_depth_ff(depth),
    .filter_reinit_ff(reinit), .soft_reset_ff(sreset), .hs_code(hs_code), .hs_mode_ff(hs_mode));
  shrp_host u_shrp_host (.sys_clk(sys_clk), .sda_line(sda_line), .sdo_line(sdo_line),
    .three_wire_select(tws), .sck(sck), .sda_drv(sda_drv), .csb_n(csb_n));
  // ****************
  // helpers
  // ****************
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic note(input string what);
    $display("test %s done", what);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [7:0] exp_rd(input int a);
    if (a > 255) return 8'h00;
    case (a)
      8'hd1: return PID;
      8'he0: return 8'h00;
      8'hf1: return {5'h00, sm};
      8'hf2: return {5'h00, hc};
      default: return 8'(a) ^ 8'h5a;
    endcase
  endfunction
  task automatic i2c_wr(input logic [6:0] dev, input logic [7:0] d [$]);
    logic [7:0] r;
    logic       a;
    u_shrp_host.i2c_start();
    u_shrp_host.i2c_byte({dev, 1'b0}, 1'b1, r, nak);
    foreach (d[i]) u_shrp_host.i2c_byte(d[i], 1'b1, r, a);
    u_shrp_host.i2c_stop();
  endtask
  task automatic rd_chk(input logic [7:0] a, input int n);
    logic [7:0] r;
    logic       x;
    u_shrp_host.i2c_start();
    u_shrp_host.i2c_byte(8'he0, 1'b1, r, x);
    u_shrp_host.i2c_byte(a, 1'b1, r, x);
    u_shrp_host.i2c_restart();
    u_shrp_host.i2c_byte(8'he1, 1'b1, r, x);
    for (int i = 0; i < n; i++) begin
      u_shrp_host.i2c_byte(8'hff, i == n - 1, r, x);
      chk8("i2c read", exp_rd(a + i), r);
    end
    u_shrp_host.i2c_stop();
  endtask
  task automatic spi(input logic [7:0] tx [$]);
    logic [7:0] r;
    q = {};
    u_shrp_host.spi_begin();
    foreach (tx[i]) begin
      u_shrp_host.xfer(tx[i], r);
      q.push_back(r);
    end
    u_shrp_host.spi_end();
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    end_of_test();
  end
  initial begin
    w(3);
    rst <= 1'b0;
    w(6);
    foreach (rows[i]) begin
      k = n_re;
      sm = rows[i][8:6];
      hc = rows[i][8:6];
      i2c_wr(7'h70, '{8'hf1, {5'h00, sm}, 8'hf2, {5'h00, hc}});
      chk8("ack", 8'h00, {7'h00, nak});
      chk8("depth", {2'h0, rows[i][5:0]}, {2'h0, depth});
      chk8("hs_code", {5'h01, hc}, hs_code);
      chk8("reinit", 8'h01, 8'(n_re - k));
    end
    note("config rows");
    rst <= 1'b1;
    w(3);
    rst <= 1'b0;
    w(6);
    sm = 3'h0;
    hc = 3'h1;
    chk8("hs_code", 8'h09, hs_code);
    chk8("depth", 8'h00, {2'h0, depth});
    rd_chk(8'hf1, 2);
    rd_chk(8'hd0, 3);
    rd_chk(8'hfe, 4);
    note("reset and bursts");
    addr_sel <= 1'b1;
    w(4);
    i2c_wr(7'h70, '{8'hf1, 8'h01});
    chk8("wrong address", 8'h01, {7'h00, nak});
    i2c_wr(7'h56, '{8'hf1, 8'h01});
    chk8("ack", 8'h00, {7'h00, nak});
    chk8("depth", 8'h02, {2'h0, depth});
    addr_sel <= 1'b0;
    k = n_sr;
    i2c_wr(7'h70, '{8'he0, 8'he5, 8'hf2, 8'h05});
    chk8("soft reset", 8'h00, 8'(n_sr - k));
    chk8("hs_code", 8'h0d, hs_code);
    i2c_wr(7'h70, '{8'he0, 8'he6, 8'h80, 8'hc3});
    chk8("soft reset", 8'h01, 8'(n_sr - k));
    chk8("hs_code", 8'h09, hs_code);
    chk8("depth", 8'h00, {2'h0, depth});
    chk8("core write", 8'hc3, mem[8'h80]);
    note("address select and soft reset");
    // a code one off the selected one must not switch to high speed
    u_shrp_host.i2c_start();
    u_shrp_host.i2c_byte(8'h0a, 1'b1, r0, nak);
    chk8("hs_mode", 8'h00, {7'h00, hs_mode});
    u_shrp_host.i2c_restart();
    u_shrp_host.i2c_byte(8'h09, 1'b1, r0, nak);
    chk8("master code nack", 8'h01, {7'h00, nak});
    chk8("hs_mode", 8'h01, {7'h00, hs_mode});
    u_shrp_host.i2c_stop();
    chk8("hs_mode", 8'h00, {7'h00, hs_mode});
    note("master code");
    k = n_re;
    spi('{8'h71, 8'h04, 8'h72, 8'h03});
    sm = 3'h4;
    hc = 3'h3;
    chk8("depth", 8'h10, {2'h0, depth});
    chk8("hs_code", 8'h0b, hs_code);
    // a data byte cut short by csb must leave the register alone
    u_shrp_host.spi_begin();
    u_shrp_host.xfer(8'h71, r0);
    repeat (4) u_shrp_host.bit1(1'b1, b);
    u_shrp_host.spi_end();
    chk8("reinit", 8'h01, 8'(n_re - k));
    chk8("depth", 8'h10, {2'h0, depth});
    for (int t = 0; t < 2; t++) begin
      tws <= t[0];
      w(2);
      r0 = t ? 8'hd0 : 8'hf0;
      spi('{r0, 8'hff, 8'hff, 8'hff});
      for (int i = 1; i < 4; i++) chk8("spi read", exp_rd(r0 + i - 1), q[i]);
    end
    tws <= 1'b0;
    note("spi");
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
